// ===== hdl/port_arbitration_table.sv
// Port arbitration table with load/coherency control and slot-walking arbiter
`timescale 1ns/100ps
`default_nettype none
module port_arbitration_table #(
    parameter logic [3:0] EGRESS_PORT = port_arb_pkg::EGRESS_DEFAULT
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire port_arb_pkg::reg_req_t regReq,
    output logic [31:0] rdData,
    input wire logic [15:0] portRequest,
    input wire logic periodDone,
    output port_arb_pkg::grant_t grant
);
    import port_arb_pkg::*;

    // Code to port number; PORT15 also marks an unusable code
    function automatic logic [3:0] portOf(input logic [3:0] code);
        if (code <= CODE_LAST_DIRECT) begin
            portOf = code;
        end else if (code == CODE_PORT15) begin
            portOf = PORT15;
        end else begin
            portOf = PORT15;
        end
    endfunction

    function automatic logic codeValid(input logic [3:0] code);
        codeValid = (code <= CODE_PORT15) && (portOf(code) != EGRESS_PORT);
    endfunction

    function automatic logic [3:0] slotCode(input logic [127:0] flat, input logic [4:0] k);
        slotCode = flat[{k, 2'b00} +: SLOT_W];
    endfunction

    logic [31:0] tableWord_q [WORDS];
    logic [31:0] activeWord_q [WORDS];
    logic [2:0] schemeSel_q;
    logic pending_q;
    load_state_t ldState_q;
    logic [1:0] ldIdx_q;
    logic [4:0] slotPtr_q;
    grant_t grant_q;
    logic [31:0] rdData_q;

    wire logic [1:0] wordIdx = regReq.addr[3:2];
    wire logic tblHit = (regReq.addr[ADDR_W-1:4] == TBL_WORD0_ADDR[ADDR_W-1:4])
        && (regReq.addr[1:0] == 2'b00);
    wire logic ctrlHit = (regReq.addr == CTRL_ADDR);
    wire logic statHit = (regReq.addr == STAT_ADDR);
    wire logic tblWr = regReq.wr && tblHit;
    wire logic ctrlWr = regReq.wr && ctrlHit;
    wire logic tableUsed = (schemeSel_q == SCHEME_TABLE);
    // Load only under a table scheme, and not while a copy is running
    wire logic loadStart = ctrlWr && regReq.wdata[LOAD_REQ_BIT] && tableUsed
        && (ldState_q == LD_IDLE);
    wire logic loadDone = (ldState_q == LD_COPY) && (ldIdx_q == 2'd3);
    wire logic [127:0] activeFlat = {activeWord_q[3], activeWord_q[2],
        activeWord_q[1], activeWord_q[0]};

    // Load bit is write-only and always reads zero
    wire logic [31:0] ctrlRead = {12'h0, schemeSel_q, 1'b0, 16'h0};
    wire logic [31:0] statRead = {15'h0, pending_q, 16'h0};
    wire logic [31:0] rdNext = tblHit ? tableWord_q[wordIdx] :
        ctrlHit ? ctrlRead : statHit ? statRead : 32'h0;

    // Search from the pointer for the first usable slot, all in one cycle
    // Long path, traded for skipping invalid slots at no time cost
    logic found;
    logic [4:0] selSlot;
    always_comb begin
        logic [4:0] k;
        k = 5'd0;
        found = 1'b0;
        selSlot = slotPtr_q;
        for (int i = 0; i < SLOTS; i++) begin
            k = slotPtr_q + 5'(i);
            if (!found && codeValid(slotCode(activeFlat, k))) begin
                found = 1'b1;
                selSlot = k;
            end
        end
    end

    wire logic [3:0] selPort = portOf(slotCode(activeFlat, selSlot));
    wire logic advance = periodDone && tableUsed && found;
    wire grant_t grantNext = '{valid: tableUsed && found && portRequest[selPort],
        port: selPort, slot: selSlot};

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < WORDS; i++) begin
                tableWord_q[i] <= TABLE_RESET;
                activeWord_q[i] <= TABLE_RESET;
            end
        end else begin
            if (tblWr) begin
                tableWord_q[wordIdx] <= regReq.wdata;
            end
            // Copy one word per cycle so the load has a visible end
            if (ldState_q == LD_COPY) begin
                activeWord_q[ldIdx_q] <= tableWord_q[ldIdx_q];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            schemeSel_q <= SCHEME_RESET;
            ldState_q <= LD_IDLE;
            ldIdx_q <= 2'd0;
        end else begin
            if (ctrlWr) begin
                schemeSel_q <= regReq.wdata[SCHEME_LSB +: 3];
            end
            case (ldState_q)
                LD_IDLE: begin
                    ldIdx_q <= 2'd0;
                    if (loadStart) begin
                        ldState_q <= LD_COPY;
                    end
                end
                LD_COPY: begin
                    ldIdx_q <= ldIdx_q + 2'd1;
                    if (loadDone) begin
                        ldState_q <= LD_IDLE;
                    end
                end
                default: begin
                    ldState_q <= LD_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pending_q <= 1'b0;
        end else if (tblWr) begin
            pending_q <= 1'b1;
        end else if (loadDone) begin
            pending_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            slotPtr_q <= 5'd0;
            grant_q <= '0;
            rdData_q <= 32'h0;
        end else begin
            if (advance) begin
                slotPtr_q <= selSlot + 5'd1;
            end
            grant_q <= grantNext;
            rdData_q <= regReq.rd ? rdNext : 32'h0;
        end
    end

    assign rdData = rdData_q;
    assign grant = grant_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    grant_names_port_a: assert property (grantNext.valid |=> grant.valid
        && grant.port == portOf(slotCode(activeFlat, grant.slot)) || $past(ldState_q == LD_COPY))
        else $error("grant port differs from slot entry");
    slot_packing_a: assert property (slotCode(activeFlat, 5'd9)
        == activeWord_q[1][7:4] && slotCode(activeFlat, 5'd31) == activeWord_q[3][31:28])
        else $error("slot packing wrong");
    code_map_a: assert property (grant.valid |-> grant.port != 4'he
        && grant.port != EGRESS_PORT)
        else $error("grant to unnamed or egress port");
    skip_invalid_a: assert property (found |-> codeValid(slotCode(activeFlat, selSlot)))
        else $error("invalid slot selected");
    load_copy_a: assert property (loadStart |=> (ldState_q == LD_COPY)[*4]
        ##1 ldState_q == LD_IDLE)
        else $error("load copy length wrong");
    load_reads_zero_a: assert property (regReq.rd && ctrlHit |=> !rdData[LOAD_REQ_BIT])
        else $error("load bit read as one");
    pending_set_a: assert property (tblWr |=> pending_q)
        else $error("pending not set by table write");
    pending_clear_a: assert property ($fell(pending_q) |-> $past(loadDone))
        else $error("pending cleared without load");
    scheme_gate_a: assert property (!tableUsed |=> !grant.valid &&
        !($rose(ldState_q == LD_COPY)))
        else $error("table acted without table scheme");
    slot_step_a: assert property (advance |=> slotPtr_q == $past(selSlot) + 5'd1)
        else $error("slot pointer did not step");

    // Hold and wrap checks: nothing moves unless its own trigger fired
    ptr_hold_a: assert property (!advance |=> $stable(slotPtr_q))
        else $error("slot pointer moved without period end");
    slot_wrap_a: assert property (advance && selSlot == 5'd31 |=> slotPtr_q == 5'd0)
        else $error("slot pointer did not wrap");
    active_hold_a: assert property (ldState_q == LD_IDLE |=> $stable(activeFlat))
        else $error("active table changed outside a load");
    pending_hold_a: assert property (pending_q && !loadDone |=> pending_q)
        else $error("pending cleared before load finished");
    // Set beats clear when a table write meets the end of a load
    pending_wins_a: assert property (tblWr && loadDone |=> pending_q)
        else $error("pending lost on write at load end");
    scheme_load_a: assert property (ctrlWr && !tableUsed && ldState_q == LD_IDLE
        |=> ldState_q == LD_IDLE)
        else $error("load started without table scheme");
    port15_code_a: assert property (grantNext.valid
        && slotCode(activeFlat, selSlot) == CODE_PORT15 |=> grant.port == PORT15)
        else $error("code 0xe not granted to port 15");
    request_gate_a: assert property (!portRequest[selPort] |=> !grant.valid)
        else $error("grant to a port that was not requesting");
    read_idle_a: assert property (!regReq.rd |=> rdData == 32'h0)
        else $error("read data outside read cycle");
endmodule
`default_nettype wire

// ===== hdl/port_arb_pkg.sv
// Constants and types for the port arbitration table block
package port_arb_pkg;
    localparam int ADDR_W = 12;
    localparam int WORDS = 4;
    localparam int SLOTS = 32;
    localparam int SLOT_W = 4;
    localparam logic [ADDR_W-1:0] TBL_WORD0_ADDR = 12'h240;
    localparam logic [ADDR_W-1:0] TBL_WORD1_ADDR = 12'h244;
    localparam logic [ADDR_W-1:0] TBL_WORD2_ADDR = 12'h248;
    localparam logic [ADDR_W-1:0] TBL_WORD3_ADDR = 12'h24c;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 12'h250;
    localparam logic [ADDR_W-1:0] STAT_ADDR = 12'h254;
    localparam int LOAD_REQ_BIT = 16;
    localparam int SCHEME_LSB = 17;
    localparam int PENDING_BIT = 16;
    localparam logic [31:0] TABLE_RESET = 32'h0;
    localparam logic [2:0] SCHEME_RESET = 3'h0;
    localparam logic [2:0] SCHEME_TABLE = 3'h1;
    localparam logic [3:0] CODE_LAST_DIRECT = 4'hd;
    localparam logic [3:0] CODE_PORT15 = 4'he;
    localparam logic [3:0] PORT15 = 4'hf;
    localparam logic [3:0] EGRESS_DEFAULT = 4'hf;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic valid;
        logic [3:0] port;
        logic [4:0] slot;
    } grant_t;

    typedef enum logic [1:0] {
        LD_IDLE = 2'b01,
        LD_COPY = 2'b10
    } load_state_t;
endpackage

// ===== sim/ingress_ports_model.sv
// Ingress port request model for the arbitration side
`timescale 1ns/100ps
`default_nettype none
module ingress_ports_model (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [15:0] reqMask,
    output logic [15:0] portRequest
);
    // Requests are levels, held until the bench withdraws them
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            portRequest <= 16'h0;
        end else begin
            portRequest <= reqMask;
        end
    end
endmodule
`default_nettype wire

// ===== sim/port_arbitration_table_tb_top.sv
// Self-checking bench for the port arbitration table
`timescale 1ns/100ps
`default_nettype none
module port_arbitration_table_tb_top;
    import port_arb_pkg::*;
    // Egress moved off 0xf so that code 0xe names a grantable port
    localparam logic [3:0] EGRESS = 4'h7;
    localparam logic [31:0] WORDS_INIT [4] = '{32'h10afde73, 32'h76543210, 32'hedcba980,
        32'hf7000000};
    // No 0xf and no egress code: software keeps to legal programming here
    localparam logic [31:0] LEGAL_WORD = 32'h6543210e;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    reg_req_t regReq = '0;
    logic [31:0] rdData;
    logic [15:0] portRequest;
    logic [15:0] reqMask = 16'hffff;
    logic periodDone = 1'b0;
    grant_t grant;
    logic [3:0] tbl [SLOTS];
    logic [4:0] walkPtr = 5'h0;
    int n_errors = 0;
    int comparisons = 0;
    always #5 sys_clk = ~sys_clk;
    port_arbitration_table #(.EGRESS_PORT(EGRESS)) port_arbitration_table_i (.sys_clk(sys_clk),
        .resetn(resetn), .regReq(regReq), .rdData(rdData), .portRequest(portRequest),
        .periodDone(periodDone), .grant(grant));
    ingress_ports_model ingress_ports_model_i (.sys_clk(sys_clk), .resetn(resetn),
        .reqMask(reqMask), .portRequest(portRequest));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        regReq.wr <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        regReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        regReq.rd <= 1'b0;
        #1 chk(rdData, exp);
        @(posedge sys_clk);
        #1 chk(rdData, 32'h0);
    endtask
    function automatic logic [3:0] portOf(input logic [3:0] c);
        return (c == CODE_PORT15) ? PORT15 : c;
    endfunction
    // Invalid codes cost no period, so the next valid slot is granted at once
    function automatic logic [4:0] pick(input logic [4:0] p);
        for (int i = 0; i < SLOTS; i++) begin
            if (tbl[5'(p + i)] != 4'hf && portOf(tbl[5'(p + i)]) != EGRESS) return 5'(p + i);
        end
        return p;
    endfunction
    task automatic t_reset();
        for (int w = 0; w < WORDS; w++) rdchk(TBL_WORD0_ADDR + 12'(4 * w), TABLE_RESET);
        rdchk(STAT_ADDR, 32'h0);
        rdchk(12'h258, 32'h0);
        rdchk(CTRL_ADDR, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_program();
        for (int w = 0; w < WORDS; w++) begin
            wr(TBL_WORD0_ADDR + 12'(4 * w), WORDS_INIT[w]);
            for (int k = 0; k < 8; k++) tbl[w * 8 + k] = WORDS_INIT[w][4 * k +: 4];
        end
        for (int w = 0; w < WORDS; w++) rdchk(TBL_WORD0_ADDR + 12'(4 * w), WORDS_INIT[w]);
        rdchk(STAT_ADDR, 32'h1 << PENDING_BIT);
        wr(CTRL_ADDR, 32'h1 << LOAD_REQ_BIT);
        repeat (6) @(posedge sys_clk);
        #1 chk(32'(grant.valid), 32'h0);
        rdchk(STAT_ADDR, 32'h1 << PENDING_BIT);
        $display("test program done");
    endtask
    task automatic t_load();
        wr(CTRL_ADDR, 32'(SCHEME_TABLE) << SCHEME_LSB);
        wr(CTRL_ADDR, (32'(SCHEME_TABLE) << SCHEME_LSB) | (32'h1 << LOAD_REQ_BIT));
        rdchk(CTRL_ADDR, 32'(SCHEME_TABLE) << SCHEME_LSB);
        repeat (4) @(posedge sys_clk);
        rdchk(STAT_ADDR, 32'h0);
        $display("test load done");
    endtask
    task automatic t_walk();
        logic [4:0] s;
        walkPtr = 5'h0;
        @(posedge sys_clk);
        for (int n = 0; n < 33; n++) begin
            s = pick(walkPtr);
            #1 chk(32'(grant.valid), 32'h1);
            chk(32'(grant.slot), 32'(s));
            chk(32'(grant.port), 32'(portOf(tbl[s])));
            @(posedge sys_clk);
            periodDone <= 1'b1;
            @(posedge sys_clk);
            periodDone <= 1'b0;
            @(posedge sys_clk);
            walkPtr = s + 5'h1;
        end
        $display("test walk done");
    endtask
    task automatic t_legal();
        for (int w = 0; w < WORDS; w++) begin
            wr(TBL_WORD0_ADDR + 12'(4 * w), LEGAL_WORD);
            for (int k = 0; k < 8; k++) tbl[w * 8 + k] = LEGAL_WORD[4 * k +: 4];
        end
        wr(CTRL_ADDR, (32'(SCHEME_TABLE) << SCHEME_LSB) | (32'h1 << LOAD_REQ_BIT));
        wr(12'h258, 32'hffffffff);
        // Lands on the last copy cycle, so set and clear meet
        wr(TBL_WORD0_ADDR, LEGAL_WORD);
        rdchk(STAT_ADDR, 32'h1 << PENDING_BIT);
        rdchk(12'h258, 32'h0);
        wr(CTRL_ADDR, (32'(SCHEME_TABLE) << SCHEME_LSB) | (32'h1 << LOAD_REQ_BIT));
        repeat (5) @(posedge sys_clk);
        #1 chk(32'(grant.valid), 32'h1);
        chk(32'(grant.slot), 32'(pick(walkPtr)));
        chk(32'(grant.port), 32'(portOf(tbl[pick(walkPtr)])));
        rdchk(STAT_ADDR, 32'h0);
        @(posedge sys_clk);
        reqMask <= 16'hffff ^ (16'h1 << portOf(tbl[pick(walkPtr)]));
        repeat (2) @(posedge sys_clk);
        #1 chk(32'(grant.valid), 32'h0);
        @(posedge sys_clk);
        reqMask <= 16'hffff;
        $display("test legal table done");
    endtask
    task automatic t_scheme_off();
        repeat (2) @(posedge sys_clk);
        #1 chk(32'(grant.valid), 32'h1);
        wr(CTRL_ADDR, 32'h0);
        @(posedge sys_clk);
        #1 chk(32'(grant.valid), 32'h0);
        rdchk(CTRL_ADDR, 32'h0);
        $display("test scheme off done");
    endtask
    task automatic t_reset_mid();
        @(posedge sys_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        #1 chk(32'(grant), 32'h0);
        chk(rdData, 32'h0);
        t_reset();
        $display("test mid reset done");
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        t_reset();
        t_program();
        t_load();
        t_walk();
        t_legal();
        t_scheme_off();
        t_reset_mid();
        print_verdict();
    end
    // Whole run needs a few hundred cycles; this margin only catches a hang
    initial begin
        #100us;
        n_errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
